// >>> hdl/fg_cal_offset_adjust_bank.sv
// module: foreground calibration offset register bank on a classic wishbone slave
`timescale 1ns/1ns
module fg_cal_offset_adjust_bank (
   input wire logic clock_i, // 20 mhz system clock
   input wire logic arst_n_i, // asynchronous reset, active low
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write enable
   input wire logic [11:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // one-cycle acknowledge
   input wire logic fuse_valid_i, // fuse words stable, one-cycle load pulse
   input wire logic [63:0] fuse_data_i, // four fuse words, register 0 in low bits
   input wire fg_cal_offset_pkg::cal_select_t select_i, // sampling state
   output logic [11:0] offset_o, // offset to add to converter output
   output logic offset_valid_o // an offset is applied this cycle
);
   logic [15:0] regs [4];
   logic [15:0] next_regs [4];
   logic [31:0] next_dat;
   logic next_ack;
   logic [11:0] next_offset;
   logic next_offset_valid;
   logic [1:0] idx;
   logic hit;
   logic req;

   always_comb begin
      req = wb_cyc_i && wb_stb_i && !wb_ack_o;
      hit = 1'b1;
      idx = 2'd0;
      case (wb_adr_i)
         fg_cal_offset_pkg::addr_conv_a_single_input_a: idx = 2'd0;
         fg_cal_offset_pkg::addr_conv_a_single_input_b: idx = 2'd1;
         fg_cal_offset_pkg::addr_conv_b_input_a: idx = 2'd2;
         fg_cal_offset_pkg::addr_conv_b_input_b: idx = 2'd3;
         default: hit = 1'b0;
      endcase
   end

   // bus side; the fuse load wins over a write in the same cycle
   always_comb begin
      for (int i = 0; i < fg_cal_offset_pkg::num_regs; i++) begin
         next_regs[i] = regs[i];
      end
      next_ack = req;
      next_dat = fg_cal_offset_pkg::unmapped_read;
      if (req && hit && !wb_we_i) begin
         next_dat = {16'h0000, regs[idx]};
      end
      if (req && hit && wb_we_i) begin
         if (wb_sel_i[0]) next_regs[idx][7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) next_regs[idx][15:8] = wb_dat_i[15:8];
      end
      if (fuse_valid_i) begin
         for (int i = 0; i < fg_cal_offset_pkg::num_regs; i++) begin
            next_regs[i] = fuse_data_i[i*16 +: 16];
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < fg_cal_offset_pkg::num_regs; i++) begin
            regs[i] <= fg_cal_offset_pkg::reg_reset;
         end
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         for (int i = 0; i < fg_cal_offset_pkg::num_regs; i++) begin
            regs[i] <= next_regs[i];
         end
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // offset selection; only bits 11:0 ever reach the datapath
   always_comb begin
      next_offset = 12'h000;
      next_offset_valid = 1'b0;
      if (select_i.cal_enable) begin
         if (select_i.conv_b) begin
            next_offset_valid = 1'b1;
            next_offset = select_i.input_b ? regs[3][11:0] : regs[2][11:0];
         end else if (!select_i.input_b && select_i.single_mode) begin
            next_offset_valid = 1'b1;
            next_offset = regs[0][11:0];
         end else if (select_i.input_b && select_i.phase_90) begin
            next_offset_valid = 1'b1;
            next_offset = regs[1][11:0];
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         offset_o <= 12'h000;
         offset_valid_o <= 1'b0;
      end else begin
         offset_o <= next_offset;
         offset_valid_o <= next_offset_valid;
      end
   end

   property p_conv_b_a;
      @(posedge clock_i) disable iff (!arst_n_i)
      (select_i.cal_enable && select_i.conv_b && !select_i.input_b && !fuse_valid_i
       && !(req && wb_we_i)) |=> (offset_o == regs[2][11:0]) && offset_valid_o;
   endproperty
   a_conv_b_a: assert property (p_conv_b_a) else $error("converter b input a offset wrong");

   property p_conv_b_b;
      @(posedge clock_i) disable iff (!arst_n_i)
      (select_i.cal_enable && select_i.conv_b && select_i.input_b && !fuse_valid_i
       && !(req && wb_we_i)) |=> (offset_o == regs[3][11:0]) && offset_valid_o;
   endproperty
   a_conv_b_b: assert property (p_conv_b_b) else $error("converter b input b offset wrong");

   property p_conv_a_a;
      @(posedge clock_i) disable iff (!arst_n_i)
      (select_i.cal_enable && !select_i.conv_b && !select_i.input_b && select_i.single_mode
       && !fuse_valid_i && !(req && wb_we_i)) |=> offset_o == regs[0][11:0];
   endproperty
   a_conv_a_a: assert property (p_conv_a_a) else $error("converter a input a offset wrong");

   property p_conv_a_b;
      @(posedge clock_i) disable iff (!arst_n_i)
      (select_i.cal_enable && !select_i.conv_b && select_i.input_b && select_i.phase_90
       && !fuse_valid_i && !(req && wb_we_i)) |=> offset_o == regs[1][11:0];
   endproperty
   a_conv_a_b: assert property (p_conv_a_b) else $error("converter a input b offset wrong");

   property p_cal_off;
      @(posedge clock_i) disable iff (!arst_n_i)
      !select_i.cal_enable |=> !offset_valid_o && offset_o == 12'h000;
   endproperty
   a_cal_off: assert property (p_cal_off) else $error("offset applied while cal disabled");

   property p_write_read;
      @(posedge clock_i) disable iff (!arst_n_i)
      (req && hit && wb_we_i && wb_sel_i[1:0] == 2'b11 && !fuse_valid_i)
      |=> regs[$past(idx)] == $past(wb_dat_i[15:0]);
   endproperty
   a_write_read: assert property (p_write_read) else $error("full write not stored");

   property p_fuse;
      @(posedge clock_i) disable iff (!arst_n_i)
      fuse_valid_i |=> regs[0] == $past(fuse_data_i[15:0]) && regs[3] == $past(fuse_data_i[63:48]);
   endproperty
   a_fuse: assert property (p_fuse) else $error("fuse defaults not loaded");

   property p_reserved;
      @(posedge clock_i) disable iff (!arst_n_i)
      select_i.cal_enable && select_i.conv_b && !select_i.input_b |=> offset_o[11:0] == $past(regs[2][11:0]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("offset width wrong");

   property p_ack;
      @(posedge clock_i) disable iff (!arst_n_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle");

   property p_unmapped;
      @(posedge clock_i) disable iff (!arst_n_i)
      req && !hit |=> wb_ack_o && wb_dat_o == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_read_data;
      @(posedge clock_i) disable iff (!arst_n_i)
      req && hit && !wb_we_i |=> wb_ack_o && wb_dat_o == {16'h0000, $past(regs[idx])};
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not the register");

   property p_lane_keep;
      @(posedge clock_i) disable iff (!arst_n_i)
      (req && hit && wb_we_i && !wb_sel_i[1] && !fuse_valid_i)
      |=> regs[$past(idx)][15:8] == $past(regs[idx][15:8]);
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("unselected byte lane written");

   property p_unmapped_write;
      @(posedge clock_i) disable iff (!arst_n_i)
      (req && !hit && wb_we_i && !fuse_valid_i) |=> regs[0] == $past(regs[0])
         && regs[1] == $past(regs[1]) && regs[2] == $past(regs[2]) && regs[3] == $past(regs[3]);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

   // a write racing the fuse load must not leave a half-programmed bank behind
   property p_fuse_wins;
      @(posedge clock_i) disable iff (!arst_n_i)
      (fuse_valid_i && req && wb_we_i) |=> regs[0] == $past(fuse_data_i[15:0])
         && regs[1] == $past(fuse_data_i[31:16]) && regs[2] == $past(fuse_data_i[47:32])
         && regs[3] == $past(fuse_data_i[63:48]);
   endproperty
   a_fuse_wins: assert property (p_fuse_wins) else $error("write beat the fuse load");

   property p_refused_a;
      @(posedge clock_i) disable iff (!arst_n_i)
      (select_i.cal_enable && !select_i.conv_b
       && ((!select_i.input_b && !select_i.single_mode) || (select_i.input_b && !select_i.phase_90)))
      |=> !offset_valid_o && offset_o == 12'h000;
   endproperty
   a_refused_a: assert property (p_refused_a) else $error("converter a offset applied");

   c_write: cover property (@(posedge clock_i) req && hit && wb_we_i);
   c_read: cover property (@(posedge clock_i) req && hit && !wb_we_i);
   c_fuse: cover property (@(posedge clock_i) fuse_valid_i);
   c_apply: cover property (@(posedge clock_i) offset_valid_o);
   c_fuse_write: cover property (@(posedge clock_i) fuse_valid_i && req && wb_we_i);
endmodule : fg_cal_offset_adjust_bank

// >>> hdl/fg_cal_offset_pkg.sv
// package: register map, field layout and datapath types for the offset bank
package fg_cal_offset_pkg;
   localparam logic [11:0] addr_conv_a_single_input_a = 12'h348;
   localparam logic [11:0] addr_conv_a_single_input_b = 12'h34a;
   localparam logic [11:0] addr_conv_b_input_a = 12'h34c;
   localparam logic [11:0] addr_conv_b_input_b = 12'h34e;
   localparam int num_regs = 4;
   localparam int offset_msb = 11;
   localparam int offset_width = 12;
   localparam int reg_width = 16;
   localparam logic [15:0] reg_reset = 16'h0000;
   localparam logic [31:0] unmapped_read = 32'h00000000;

   // which internal converter and which input the datapath is using
   typedef struct packed {
      logic cal_enable;
      logic single_mode;
      logic phase_90;
      logic conv_b;
      logic input_b;
   } cal_select_t;
endpackage : fg_cal_offset_pkg

// >>> testbench/tb.sv
// testbench: wishbone register access and offset selection checks
`timescale 1ns/1ns
module tb;
   logic clock_i;
   logic arst_n_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic fuse_valid_i;
   logic wb_ack_o;
   logic offset_valid_o;
   logic [11:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic [63:0] fuse_data_i;
   logic [11:0] offset_o;
   fg_cal_offset_pkg::cal_select_t select_i;
   int fail_count = 0;
   int checks_done = 0;
   logic [3:0] lanes = 4'h3;
   // select is {cal, single, phase90, conv b, input b}; expected is {valid, offset}
   logic [4:0] sel_tab [10] = '{5'h18, 5'h10, 5'h15, 5'h19, 5'h12, 5'h1a, 5'h13, 5'h1f,
      5'h0a, 5'h1d};
   logic [12:0] exp_tab [10] = '{13'h1123, 13'h0000, 13'h1456, 13'h0000, 13'h1789, 13'h1789,
      13'h1abc, 13'h1abc, 13'h0000, 13'h1456};
   // reserved nibbles set so a leak into the offset would show
   logic [15:0] wr_tab [4] = '{16'hf123, 16'ha456, 16'h5789, 16'h3abc};
   logic [11:0] adr_tab [4] = '{fg_cal_offset_pkg::addr_conv_a_single_input_a,
      fg_cal_offset_pkg::addr_conv_a_single_input_b, fg_cal_offset_pkg::addr_conv_b_input_a,
      fg_cal_offset_pkg::addr_conv_b_input_b};

   fg_cal_offset_adjust_bank uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .fuse_valid_i(fuse_valid_i), .fuse_data_i(fuse_data_i), .select_i(select_i),
      .offset_o(offset_o), .offset_valid_o(offset_valid_o));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task automatic give_verdict();
      if (fail_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // holds the request until ack is seen at a rising edge; with no timeout of its own, a missing ack is ended only by the watchdog
   task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= lanes;
      do begin
         @(posedge clock_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_xfer

   task automatic check_rd(input logic [31:0] exp);
      checks_done++;
      if (rd !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t read %h expected %h", $time, rd, exp);
      end
   endtask : check_rd

   task automatic check_off(input logic [12:0] exp);
      checks_done++;
      if ({offset_valid_o, offset_o} !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t offset %h expected %h", $time, offset_o, exp);
      end
   endtask : check_off

   initial begin
      arst_n_i = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, fuse_valid_i} = 4'h0;
      wb_adr_i = 12'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      fuse_data_i = 64'h0;
      select_i = '0;
      repeat (6) @(posedge clock_i);
      arst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wb_xfer(1'b0, adr_tab[i], 32'h0);
         check_rd({16'h0000, fg_cal_offset_pkg::reg_reset});
      end
      wb_xfer(1'b0, 12'h350, 32'h0);
      check_rd(fg_cal_offset_pkg::unmapped_read);
      // fuse pulse lands on the take edge of a write to the last register
      fork
         wb_xfer(1'b1, adr_tab[3], 32'h0000ffff);
         begin
            @(posedge clock_i);
            fuse_data_i <= 64'h4ddd_3ccc_2bbb_1aaa;
            fuse_valid_i <= 1'b1;
            @(posedge clock_i);
            fuse_valid_i <= 1'b0;
         end
      join
      for (int i = 0; i < 4; i++) begin
         wb_xfer(1'b0, adr_tab[i], 32'h0);
         check_rd({16'h0000, fuse_data_i[16*i +: 16]});
         wb_xfer(1'b1, adr_tab[i], {16'h0000, wr_tab[i]});
         wb_xfer(1'b0, adr_tab[i], 32'h0);
         check_rd({16'h0000, wr_tab[i]});
      end
      lanes = 4'h1;
      wb_xfer(1'b1, adr_tab[0], 32'h0000ee55);
      lanes = 4'h3;
      wb_xfer(1'b0, adr_tab[0], 32'h0);
      check_rd(32'h0000f155);
      wb_xfer(1'b1, adr_tab[0], {16'h0000, wr_tab[0]});
      wb_xfer(1'b1, 12'h350, 32'h0000ffff);
      wb_xfer(1'b0, adr_tab[0], 32'h0);
      check_rd({16'h0000, wr_tab[0]});
      for (int k = 0; k < 10; k++) begin
         @(posedge clock_i);
         select_i <= sel_tab[k];
         repeat (2) @(posedge clock_i);
         check_off(exp_tab[k]);
      end
      @(posedge clock_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      check_off(13'h0000);
      arst_n_i <= 1'b1;
      wb_xfer(1'b0, adr_tab[1], 32'h0);
      check_rd({16'h0000, fg_cal_offset_pkg::reg_reset});
      give_verdict();
   end

   initial begin
      #(50 * 5000);
      fail_count++;
      give_verdict();
   end
endmodule : tb
